// *** design/burst_if.sv ***
// Carrier between the mode block and its burst sequencer
`timescale 1ns/100ps
interface burst_if;
	import sdram_mode_pkg::*;
	logic start;
	logic [COL_W-1:0] startCol;
	logic [2:0] lenCode;
	logic interleave;
	logic [COL_W-1:0] column;
	logic beat;
	logic last;
	modport ctrl (output start, startCol, lenCode, interleave, input column, beat, last);
	modport seq (input start, startCol, lenCode, interleave, output column, beat, last);
endinterface : burst_if

// *** design/burst_sequencer.sv ***
// Column sequencer that walks one burst inside its block
`timescale 1ns/100ps
module burst_sequencer
	import sdram_mode_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	burst_if.seq bus
);
	seq_state_t state, next_state;
	logic [COL_W-1:0] count, next_count;
	logic [COL_W-1:0] remain, next_remain;
	logic [COL_W-1:0] startReg, next_startReg;
	logic [COL_W-1:0] maskReg, next_maskReg;
	logic interReg, next_interReg;
	logic [COL_W-1:0] next_column;
	logic next_beat, next_last;
	logic [COL_W-1:0] idx;

	// Low-bit mask that spans one block for a length code
	function automatic logic [COL_W-1:0] blockMask(input logic [2:0] code);
		if (code == BLEN_TWO) begin
			return 9'h001;
		end else if (code == BLEN_FOUR) begin
			return 9'h003;
		end else if (code == BLEN_EIGHT) begin
			return 9'h007;
		end else if (code == BLEN_PAGE) begin
			return 9'h1FF;
		end
		return 9'h000;
	endfunction : blockMask

	// Next column: block bits kept, low bits counted or xored
	always_comb begin
		next_state = state;
		next_count = count;
		next_remain = remain;
		next_startReg = startReg;
		next_maskReg = maskReg;
		next_interReg = interReg;
		next_column = bus.column;
		next_beat = 1'b0;
		next_last = 1'b0;
		idx = interReg ? (startReg ^ count) : COL_W'(startReg + count);
		if (bus.start) begin
			next_startReg = bus.startCol;
			next_maskReg = blockMask(bus.lenCode);
			next_interReg = bus.interleave && (bus.lenCode != BLEN_PAGE);
			next_column = bus.startCol;
			next_beat = 1'b1;
			next_count = 9'h001;
			next_remain = blockMask(bus.lenCode);
			next_last = (blockMask(bus.lenCode) == 9'h000);
			next_state = next_last ? SEQ_IDLE : SEQ_RUN;
		end else if (state == SEQ_RUN) begin
			next_column = (startReg & ~maskReg) | (idx & maskReg);
			next_beat = 1'b1;
			next_count = COL_W'(count + 9'h001);
			next_remain = COL_W'(remain - 9'h001);
			next_last = (remain == 9'h001);
			if (remain == 9'h001) begin
				next_state = SEQ_IDLE;
			end
		end
	end

	// Sequencer registers
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state <= SEQ_IDLE;
			count <= '0;
			remain <= '0;
			startReg <= '0;
			maskReg <= '0;
			interReg <= 1'b0;
			bus.column <= '0;
			bus.beat <= 1'b0;
			bus.last <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			remain <= next_remain;
			startReg <= next_startReg;
			maskReg <= next_maskReg;
			interReg <= next_interReg;
			bus.column <= next_column;
			bus.beat <= next_beat;
			bus.last <= next_last;
		end
	end

	// Every beat of a running burst stays in the block of the start
	property p_wrap;
		@(posedge mclk) disable iff (!nrst)
		(state == SEQ_RUN && !bus.start) |=> ((bus.column & ~maskReg) == (startReg & ~maskReg));
	endproperty
	a_wrap: assert property (p_wrap) else $error("burst left its block");

	// First beat is the start column itself
	property p_first;
		@(posedge mclk) disable iff (!nrst)
		bus.start |=> (bus.beat && bus.column == $past(bus.startCol));
	endproperty
	a_first: assert property (p_first) else $error("first beat column wrong");

	// Eight-beat burst gives exactly eight beats
	sequence s_eightBeats;
		bus.beat[*8] ##1 !bus.beat;
	endsequence
	property p_eightRun;
		@(posedge mclk) disable iff (!nrst)
		(bus.start && bus.lenCode == BLEN_EIGHT) |=> s_eightBeats or bus.start[*1];
	endproperty
	a_eightRun: assert property (p_eightRun) else $error("eight-beat burst length wrong");
endmodule : burst_sequencer

// *** design/sdram_mode_config.sv ***
// Mode and extended mode configuration of a low-power SDRAM
`timescale 1ns/100ps
module sdram_mode_config
	import sdram_mode_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic modeSet,
	input wire logic readCmd,
	input wire logic writeCmd,
	input wire logic bankSelectBit0,
	input wire logic bankSelectBit1,
	input wire logic [12:0] addr,
	input wire logic selfRefresh,
	output logic readBeat,
	output logic writeBeat,
	output logic lastBeat,
	output logic [COL_W-1:0] burstColumn,
	output logic [2:0] burstLengthField,
	output logic burstOrderSelect,
	output logic [2:0] readLatencyField,
	output logic singleWriteMode,
	output logic [3:0] refreshBankEnable,
	output logic [1:0] refreshFraction,
	output logic tempSensorEnable,
	output logic [1:0] tempCompRefreshField
);
	logic [12:0] modeConfig, next_modeConfig;
	logic [12:0] extendedModeConfig, next_extendedModeConfig;
	logic [PIPE_D-1:0] readPipe, next_readPipe;
	logic [COL_W-1:0] colPipe [PIPE_D];
	logic [COL_W-1:0] next_colPipe [PIPE_D];
	logic curRead, next_curRead;
	logic [3:0] next_refreshBankEnable;
	logic [1:0] next_refreshFraction;
	logic [2:0] partialArrayRefreshField;
	logic [5:0] opMode;
	logic latThree;
	logic readStart;
	logic [COL_W-1:0] readCol;
	logic [1:0] bankCode;

	burst_if bus ();

	burst_sequencer u_seq (
		.mclk(mclk),
		.nrst(nrst),
		.bus(bus)
	);

	// Field views of the two configuration registers
	assign bankCode = {bankSelectBit1, bankSelectBit0};
	assign burstLengthField = modeConfig[BLEN_LSB +: 3];
	assign burstOrderSelect = modeConfig[ORDER_BIT];
	assign readLatencyField = modeConfig[LAT_LSB +: 3];
	assign opMode = modeConfig[OPMODE_LSB +: 6];
	assign singleWriteMode = (opMode == OPMODE_SINGLE_WRITE);
	assign latThree = (readLatencyField == LAT_THREE);
	assign partialArrayRefreshField = extendedModeConfig[ARRAY_LSB +: 3];
	assign tempCompRefreshField = extendedModeConfig[TEMP_LSB +: 2];
	assign tempSensorEnable = (tempCompRefreshField == TEMP_SENSOR);

	// Mode-register-set loads one of the two registers by bank code
	always_comb begin
		next_modeConfig = modeConfig;
		next_extendedModeConfig = extendedModeConfig;
		if (modeSet && bankCode == BANK_MODE_REG) begin
			next_modeConfig = addr;
		end else if (modeSet && bankCode == BANK_EXT_REG) begin
			next_extendedModeConfig = addr;
		end
	end

	// Configuration registers
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			modeConfig <= MODE_RESET;
			extendedModeConfig <= EXT_RESET;
		end else begin
			modeConfig <= next_modeConfig;
			extendedModeConfig <= next_extendedModeConfig;
		end
	end

	// Read delay line; stage k holds a read taken k edges ago
	always_comb begin
		next_readPipe = {readPipe[PIPE_D-2:0], readCmd};
		next_colPipe[0] = addr[COL_W-1:0];
		for (int k = 1; k < PIPE_D; k++) begin
			next_colPipe[k] = colPipe[k-1];
		end
	end

	// Read delay line registers
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			readPipe <= '0;
			for (int k = 0; k < PIPE_D; k++) begin
				colPipe[k] <= '0;
			end
		end else begin
			readPipe <= next_readPipe;
			colPipe <= next_colPipe;
		end
	end

	// Start a read one edge before its data edge; writes start at once
	assign readStart = latThree ? readPipe[LAT_THREE_CYCLES-1] : readPipe[LAT_TWO_CYCLES-1];
	assign readCol = latThree ? colPipe[LAT_THREE_CYCLES-1] : colPipe[LAT_TWO_CYCLES-1];
	always_comb begin
		bus.start = writeCmd || readStart;
		bus.startCol = writeCmd ? addr[COL_W-1:0] : readCol;
		bus.interleave = burstOrderSelect;
		bus.lenCode = burstLengthField;
		if (writeCmd && singleWriteMode) begin
			bus.lenCode = BLEN_ONE;
		end
		next_curRead = curRead;
		if (writeCmd) begin
			next_curRead = 1'b0;
		end else if (readStart) begin
			next_curRead = 1'b1;
		end
	end

	// Partial-array mask, applied only while in self refresh
	always_comb begin
		next_refreshBankEnable = 4'hF;
		next_refreshFraction = FRAC_FULL;
		case (partialArrayRefreshField)
			ARRAY_TWO: next_refreshBankEnable = 4'h3;
			ARRAY_ONE: next_refreshBankEnable = 4'h1;
			ARRAY_HALF: begin
				next_refreshBankEnable = 4'h1;
				next_refreshFraction = FRAC_HALF;
			end
			ARRAY_QUARTER: begin
				next_refreshBankEnable = 4'h1;
				next_refreshFraction = FRAC_QUARTER;
			end
			default: next_refreshBankEnable = 4'hF;
		endcase
		if (!selfRefresh) begin
			next_refreshBankEnable = 4'h0;
			next_refreshFraction = FRAC_FULL;
		end
	end

	// Burst kind and refresh registers
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			curRead <= 1'b0;
			refreshBankEnable <= 4'h0;
			refreshFraction <= FRAC_FULL;
		end else begin
			curRead <= next_curRead;
			refreshBankEnable <= next_refreshBankEnable;
			refreshFraction <= next_refreshFraction;
		end
	end

	// Beat strobes and column from the sequencer
	assign readBeat = bus.beat && curRead;
	assign writeBeat = bus.beat && !curRead;
	assign lastBeat = bus.last;
	assign burstColumn = bus.column;

	// Quiet window after a read: no write to pre-empt it, no latency change
	sequence s_quiet2;
		(!writeCmd && !modeSet)[*2];
	endsequence

	// Latency two: beat registered at edge n plus 2, seen from the next edge
	property p_latTwo;
		@(posedge mclk) disable iff (!nrst)
		(readCmd && !writeCmd && !latThree && !modeSet) ##1 s_quiet2 |=> readBeat;
	endproperty
	a_latTwo: assert property (p_latTwo) else $error("latency two data late");

	// Latency three: nothing at n plus 2, beat at n plus 3, from an idle pipe
	property p_latThree;
		@(posedge mclk) disable iff (!nrst)
		(readCmd && !writeCmd && latThree && !modeSet && !bus.beat && readPipe == '0)
			##1 s_quiet2 ##1 (!writeCmd && !modeSet) |=> readBeat && !$past(readBeat);
	endproperty
	a_latThree: assert property (p_latThree) else $error("latency three data wrong");

	// Single-write mode gives exactly one write beat
	property p_single;
		@(posedge mclk) disable iff (!nrst)
		(writeCmd && singleWriteMode) ##1 (!writeCmd && !readStart) |-> writeBeat ##1 !writeBeat;
	endproperty
	a_single: assert property (p_single) else $error("write not single beat");

	// Mode register load
	property p_modeLoad;
		@(posedge mclk) disable iff (!nrst)
		(modeSet && bankCode == BANK_MODE_REG) |=> modeConfig == $past(addr);
	endproperty
	a_modeLoad: assert property (p_modeLoad) else $error("mode register not loaded");

	// Extended register load and retention
	property p_extLoad;
		@(posedge mclk) disable iff (!nrst)
		(modeSet && bankCode == BANK_EXT_REG) |=> extendedModeConfig == $past(addr);
	endproperty
	a_extLoad: assert property (p_extLoad) else $error("extended register not loaded");

	property p_extKeep;
		@(posedge mclk) disable iff (!nrst)
		!(modeSet && bankCode == BANK_EXT_REG) |=> $stable(extendedModeConfig);
	endproperty
	a_extKeep: assert property (p_extKeep) else $error("extended register changed");

	// Partial-array refresh masks
	property p_pasrOne;
		@(posedge mclk) disable iff (!nrst)
		(selfRefresh && partialArrayRefreshField == ARRAY_ONE) |=> refreshBankEnable == 4'h1;
	endproperty
	a_pasrOne: assert property (p_pasrOne) else $error("bank zero mask wrong");

	property p_pasrQuarter;
		@(posedge mclk) disable iff (!nrst)
		(selfRefresh && partialArrayRefreshField == ARRAY_QUARTER)
			|=> refreshFraction == FRAC_QUARTER && refreshBankEnable == 4'h1;
	endproperty
	a_pasrQuarter: assert property (p_pasrQuarter) else $error("quarter bank wrong");

	// Sensor follows the temperature code written one edge earlier
	property p_sensor;
		@(posedge mclk) disable iff (!nrst)
		(modeSet && bankCode == BANK_EXT_REG) |=> tempSensorEnable == ($past(addr[4:3]) == 2'h0);
	endproperty
	a_sensor: assert property (p_sensor) else $error("sensor enable wrong");
endmodule : sdram_mode_config

// *** design/sdram_mode_pkg.sv ***
// Constants and types for the SDRAM mode configuration block
package sdram_mode_pkg;
	// Bank codes that steer a mode-register-set
	localparam logic [1:0] BANK_MODE_REG = 2'h0;
	localparam logic [1:0] BANK_EXT_REG = 2'h2;
	// Mode register field positions
	localparam int BLEN_LSB = 0;
	localparam int ORDER_BIT = 3;
	localparam int LAT_LSB = 4;
	localparam int OPMODE_LSB = 7;
	// Extended register field positions
	localparam int ARRAY_LSB = 0;
	localparam int TEMP_LSB = 3;
	// Reset values: burst four, sequential, latency two, normal mode
	localparam logic [12:0] MODE_RESET = 13'h0022;
	// Reset values: all four banks refreshed, sensor on
	localparam logic [12:0] EXT_RESET = 13'h0000;
	// Operating-mode codes
	localparam logic [5:0] OPMODE_NORMAL = 6'h00;
	localparam logic [5:0] OPMODE_SINGLE_WRITE = 6'h04;
	// Read latency codes and their cycle counts
	localparam logic [2:0] LAT_TWO = 3'h2;
	localparam logic [2:0] LAT_THREE = 3'h3;
	localparam int LAT_TWO_CYCLES = 2;
	localparam int LAT_THREE_CYCLES = 3;
	// Temperature-compensation code that enables the sensor
	localparam logic [1:0] TEMP_SENSOR = 2'h0;
	// Column address width and read pipeline depth
	localparam int COL_W = 9;
	localparam int PIPE_D = LAT_THREE_CYCLES;
	typedef enum logic [2:0] {
		BLEN_ONE = 3'b000,
		BLEN_TWO = 3'b001,
		BLEN_FOUR = 3'b010,
		BLEN_EIGHT = 3'b011,
		BLEN_PAGE = 3'b111
	} burst_len_t;
	typedef enum logic [2:0] {
		ARRAY_ALL = 3'b000,
		ARRAY_TWO = 3'b001,
		ARRAY_ONE = 3'b010,
		ARRAY_HALF = 3'b101,
		ARRAY_QUARTER = 3'b110
	} array_sel_t;
	typedef enum logic [1:0] {
		FRAC_FULL = 2'b00,
		FRAC_HALF = 2'b01,
		FRAC_QUARTER = 2'b10
	} refresh_frac_t;
	typedef enum logic {
		SEQ_IDLE = 1'b0,
		SEQ_RUN = 1'b1
	} seq_state_t;
endpackage : sdram_mode_pkg

// *** verification/sdram_ctrl_model.sv ***
// Behavioural memory controller that issues mode, read, write and refresh commands
`timescale 1ns/100ps
module sdram_ctrl_model
	import sdram_mode_pkg::*;
(
	input wire logic mclk,
	output logic modeSet,
	output logic readCmd,
	output logic writeCmd,
	output logic bankSelectBit0,
	output logic bankSelectBit1,
	output logic [12:0] addr,
	output logic selfRefresh
);
	// Quiet command lines from time zero
	initial begin
		modeSet = 1'b0;
		readCmd = 1'b0;
		writeCmd = 1'b0;
		bankSelectBit0 = 1'b0;
		bankSelectBit1 = 1'b0;
		addr = 13'h0000;
		selfRefresh = 1'b0;
	end

	// One command for one cycle, then the released address shows its inverse
	task automatic cmd(input logic m, input logic r, input logic w, input logic [1:0] ba,
		input logic [12:0] a);
		@(negedge mclk);
		modeSet = m;
		readCmd = r;
		writeCmd = w;
		{bankSelectBit1, bankSelectBit0} = ba;
		addr = a;
		@(negedge mclk);
		{modeSet, readCmd, writeCmd, bankSelectBit1, bankSelectBit0} = 5'h00;
		addr = ~a;
	endtask : cmd

	// Mode load: only defined operating codes, then a settling gap
	task automatic modeReg(input logic [12:0] v);
		if (v[12:7] == OPMODE_NORMAL || v[12:7] == OPMODE_SINGLE_WRITE) begin
			cmd(1'b1, 1'b0, 1'b0, BANK_MODE_REG, v);
		end
		repeat (2) @(negedge mclk);
	endtask : modeReg

	// Extended load with unused bits zero, issued only between bursts
	task automatic extReg(input logic [1:0] tempCode, input logic [2:0] arraySel);
		cmd(1'b1, 1'b0, 1'b0, BANK_EXT_REG, {8'h00, tempCode, arraySel});
		repeat (2) @(negedge mclk);
	endtask : extReg

	// Self refresh level
	task automatic refresh(input logic on);
		@(negedge mclk);
		selfRefresh = on;
	endtask : refresh
endmodule : sdram_ctrl_model

// *** verification/sdram_mode_config_tb.sv ***
// Self-checking bench for the SDRAM mode configuration block
`timescale 1ns/100ps
module sdram_mode_config_tb
	import sdram_mode_pkg::*;
;
	logic mclk, nrst, modeSet, readCmd, writeCmd, bankSelectBit0, bankSelectBit1, selfRefresh;
	logic [12:0] addr;
	logic readBeat, writeBeat, lastBeat, burstOrderSelect, singleWriteMode, tempSensorEnable;
	logic [COL_W-1:0] burstColumn;
	logic [2:0] burstLengthField, readLatencyField;
	logic [3:0] refreshBankEnable;
	logic [1:0] refreshFraction, tempCompRefreshField;
	int fails = 0;
	int samplesChecked = 0;

	sdram_mode_config dut (.mclk(mclk), .nrst(nrst), .modeSet(modeSet), .readCmd(readCmd),
		.writeCmd(writeCmd), .bankSelectBit0(bankSelectBit0), .bankSelectBit1(bankSelectBit1),
		.addr(addr), .selfRefresh(selfRefresh), .readBeat(readBeat), .writeBeat(writeBeat),
		.lastBeat(lastBeat), .burstColumn(burstColumn), .burstLengthField(burstLengthField),
		.burstOrderSelect(burstOrderSelect), .readLatencyField(readLatencyField),
		.singleWriteMode(singleWriteMode), .refreshBankEnable(refreshBankEnable),
		.refreshFraction(refreshFraction), .tempSensorEnable(tempSensorEnable),
		.tempCompRefreshField(tempCompRefreshField));

	sdram_ctrl_model ctl (.mclk(mclk), .modeSet(modeSet), .readCmd(readCmd),
		.writeCmd(writeCmd), .bankSelectBit0(bankSelectBit0), .bankSelectBit1(bankSelectBit1),
		.addr(addr), .selfRefresh(selfRefresh));

	// Free-running 100 MHz clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("checked=%0d mismatches=%0d", samplesChecked, fails);
		if (fails == 0 && samplesChecked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize

	// Load the mode register and confirm every field
	task automatic setMode(input logic [5:0] op, input logic [2:0] lat, input logic il,
		input logic [2:0] len);
		ctl.modeReg({op, lat, il, len});
		check(burstLengthField, len);
		check(burstOrderSelect, il);
		check(readLatencyField, lat);
		check(singleWriteMode, op == OPMODE_SINGLE_WRITE);
	endtask : setMode

	// Read burst: latency gap, then block-wrapped columns
	task automatic readBurst(input logic [8:0] col, input int nBeats, input logic il,
		input int lat);
		logic [8:0] mask;
		logic [8:0] exp;
		mask = 9'(nBeats - 1);
		ctl.cmd(1'b0, 1'b1, 1'b0, BANK_MODE_REG, {4'h0, col});
		for (int j = 1; j < lat; j++) begin
			@(negedge mclk);
			check(readBeat, 1'b0);
		end
		for (int i = 0; i < nBeats; i++) begin
			@(negedge mclk);
			exp = (col & ~mask) | ((il ? (col ^ 9'(i)) : (col + 9'(i))) & mask);
			check(readBeat, 1'b1);
			check(burstColumn, exp);
			check(lastBeat, i == nBeats - 1);
		end
		@(negedge mclk);
		check(readBeat, 1'b0);
	endtask : readBurst

	// Write burst of n beats from the next edge
	task automatic writeBurst(input logic [8:0] col, input int blockLen, input int n);
		logic [8:0] mask;
		mask = 9'(blockLen - 1);
		ctl.cmd(1'b0, 1'b0, 1'b1, BANK_MODE_REG, {4'h0, col});
		// First beat already stands when the command is released
		for (int i = 0; i < n; i++) begin
			check(writeBeat, 1'b1);
			check(burstColumn, (col & ~mask) | ((col + 9'(i)) & mask));
			check(lastBeat, i == n - 1);
			@(negedge mclk);
		end
		check(writeBeat, 1'b0);
	endtask : writeBurst

	task automatic scReset();
		check(burstLengthField, BLEN_FOUR);
		check(readLatencyField, LAT_TWO);
		check(singleWriteMode, 1'b0);
		check(tempSensorEnable, 1'b1);
		check(refreshBankEnable, 4'h0);
	endtask : scReset

	task automatic scReads();
		setMode(OPMODE_NORMAL, LAT_TWO, 1'b0, BLEN_TWO);
		readBurst(9'h001, 2, 1'b0, LAT_TWO_CYCLES);
		setMode(OPMODE_NORMAL, LAT_THREE, 1'b1, BLEN_FOUR);
		readBurst(9'h105, 4, 1'b1, LAT_THREE_CYCLES);
		setMode(OPMODE_NORMAL, LAT_TWO, 1'b0, BLEN_EIGHT);
		readBurst(9'h00E, 8, 1'b0, LAT_TWO_CYCLES);
		setMode(OPMODE_NORMAL, LAT_THREE, 1'b1, BLEN_EIGHT);
		readBurst(9'h1F5, 8, 1'b1, LAT_THREE_CYCLES);
		setMode(OPMODE_NORMAL, LAT_TWO, 1'b0, BLEN_ONE);
		readBurst(9'h0A3, 1, 1'b0, LAT_TWO_CYCLES);
		// Full page runs sequential even with the interleave bit set
		setMode(OPMODE_NORMAL, LAT_THREE, 1'b1, BLEN_PAGE);
		readBurst(9'h1FE, 512, 1'b0, LAT_THREE_CYCLES);
	endtask : scReads

	task automatic scWrites();
		setMode(OPMODE_NORMAL, LAT_TWO, 1'b0, BLEN_TWO);
		writeBurst(9'h003, 2, 2);
		setMode(OPMODE_SINGLE_WRITE, LAT_TWO, 1'b0, BLEN_FOUR);
		writeBurst(9'h006, 4, 1);
		readBurst(9'h006, 4, 1'b0, LAT_TWO_CYCLES);
	endtask : scWrites

	// Partial-array and temperature codes, each array mask seen in self refresh
	task automatic scExtended();
		logic [2:0] code [5] = '{ARRAY_ALL, ARRAY_TWO, ARRAY_ONE, ARRAY_HALF, ARRAY_QUARTER};
		logic [3:0] banks [5] = '{4'hF, 4'h3, 4'h1, 4'h1, 4'h1};
		logic [1:0] frac [5] = '{FRAC_FULL, FRAC_FULL, FRAC_FULL, FRAC_HALF, FRAC_QUARTER};
		logic [1:0] tc;
		for (int i = 0; i < 5; i++) begin
			tc = 2'((i + 1) % 4);
			ctl.extReg(tc, code[i]);
			check(tempCompRefreshField, tc);
			check(tempSensorEnable, tc == TEMP_SENSOR);
			ctl.refresh(1'b1);
			@(negedge mclk);
			check(refreshBankEnable, banks[i]);
			check(refreshFraction, frac[i]);
			ctl.refresh(1'b0);
			@(negedge mclk);
			check(refreshBankEnable, 4'h0);
		end
		setMode(OPMODE_NORMAL, LAT_TWO, 1'b0, BLEN_FOUR);
		check(tempCompRefreshField, 2'h1);
	endtask : scExtended

	// Bank codes 01 and 11 load nothing
	task automatic scRefused();
		ctl.cmd(1'b1, 1'b0, 1'b0, 2'h1, 13'h0033);
		ctl.cmd(1'b1, 1'b0, 1'b0, 2'h3, 13'h001B);
		repeat (2) @(negedge mclk);
		check(burstLengthField, BLEN_FOUR);
		check(tempCompRefreshField, 2'h1);
	endtask : scRefused

	// Reset, then the scenarios in turn
	initial begin
		nrst = 1'b0;
		repeat (20) @(negedge mclk);
		scReset();
		nrst = 1'b1;
		scReads();
		scWrites();
		scExtended();
		scRefused();
		summarize();
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		summarize();
	end
endmodule : sdram_mode_config_tb
